// file: rtl/sensor_device.sv
// sensor end: serial register slave, clock management and power states
`timescale 1ns/1ns
module sensor_device
   import sensor_seq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   sensor_link_if.device link,
   output logic [5:0] powerState,
   output logic pllLocked,
   output logic logicClkOn,
   output logic sequencerOn
);
   typedef struct packed {
      logic [1:0] sclkS; // synchronisers, [0] feeds [1] only
      logic [1:0] csS;
      logic [1:0] mosiS;
      logic [1:0] rstS;
      logic sclkPrev;
      logic [4:0] bitCnt;
      logic [24:0] rxShift;
      logic [15:0] txShift;
      logic miso;
      logic [15:0] sensorType;
      logic [15:0] pllSoftRst;
      logic [15:0] cgSoftRst;
      logic [15:0] pllCtrl;
      logic [15:0] pllCfg;
      logic [15:0] clkIn;
      logic [15:0] lockA;
      logic [15:0] lockB;
      logic [15:0] clkMgmt;
      logic [15:0] logicEn;
      logic [15:0] seqEn;
      logic [9:0] lockCnt;
      logic locked;
      logic logicClk; // logic clock flag, flopped for the output
      sensor_state_e state;
   } dev_s;
   dev_s r_reg, r_next;
   logic rise, fall; // synchronised sclk edges
   logic pllOn, clkRunning, logicRun;
   logic [8:0] rxAddr;
   logic [25:0] frame;

   // registers still open while clocks are down
   function automatic logic clockReg(input logic [8:0] a);
      clockReg = (a == A_SENSOR_TYPE) || (a == A_PLL_SOFT_RESET) ||
         (a == A_CLK_GEN_SOFT_RESET) || (a == A_PLL_CONTROL) ||
         (a == A_PLL_CONFIG) || (a == A_CLOCK_INPUT) || (a == A_LOCK_A) ||
         (a == A_LOCK_B) || (a == A_CLOCK_MGMT) || (a == A_PLL_STATUS);
   endfunction

   // read data mux
   function automatic logic [15:0] readReg(input dev_s s, input logic [8:0] a);
      case (a)
         A_SENSOR_TYPE: readReg = s.sensorType;
         A_PLL_SOFT_RESET: readReg = s.pllSoftRst;
         A_CLK_GEN_SOFT_RESET: readReg = s.cgSoftRst;
         A_PLL_CONTROL: readReg = s.pllCtrl;
         A_PLL_CONFIG: readReg = s.pllCfg;
         A_CLOCK_INPUT: readReg = s.clkIn;
         A_LOCK_A: readReg = s.lockA;
         A_LOCK_B: readReg = s.lockB;
         A_CLOCK_MGMT: readReg = s.clkMgmt;
         A_LOGIC_ENABLE: readReg = s.logicEn;
         A_SEQ_ENABLE: readReg = s.seqEn;
         A_PLL_STATUS: readReg = {15'h0000, s.locked};
         default: readReg = REG_CLEAR;
      endcase
   endfunction

   // state decode from what the controller has written
   always_comb
   begin
      rise = r_reg.sclkS[1] && !r_reg.sclkPrev;
      fall = !r_reg.sclkS[1] && r_reg.sclkPrev;
      pllOn = (r_reg.pllCtrl == PLL_ENABLE) && (r_reg.pllSoftRst == REG_CLEAR);
      clkRunning = pllOn || (r_reg.pllCtrl == PLL_BYPASS) || r_reg.clkIn[0];
      logicRun = clkRunning && (r_reg.locked || !pllOn) &&
         (r_reg.cgSoftRst == REG_CLEAR) && |(r_reg.clkMgmt & CM_LOGIC_CLK);
      // nine address bits have just been shifted in when the read flag arrives
      rxAddr = r_reg.rxShift[8:0];
      frame = {r_reg.rxShift, r_reg.mosiS[1]};
   end

   // next state of everything
   always_comb
   begin
      r_next = r_reg;
      r_next.sclkS = {r_reg.sclkS[0], link.sclk};
      r_next.csS = {r_reg.csS[0], link.csN};
      r_next.mosiS = {r_reg.mosiS[0], link.mosi};
      r_next.rstS = {r_reg.rstS[0], link.resetN};
      r_next.sclkPrev = r_reg.sclkS[1];
      if (r_reg.csS[1])
      begin
         // frame idle: restart bit count
         r_next.bitCnt = 5'h00;
      end
      else if (rise && r_reg.bitCnt < 5'(FRAME_BITS))
      begin
         r_next.rxShift = frame[24:0];
         r_next.bitCnt = r_reg.bitCnt + 5'h01;
         // read flag just arrived: load answer, closed registers read zero
         if (r_reg.bitCnt == 5'(ADDR_BITS) && r_reg.mosiS[1])
         begin
            if (clockReg(rxAddr) || r_reg.state[3] || r_reg.state[4] || r_reg.state[5])
               r_next.txShift = readReg(r_reg, rxAddr); // [RULE16] [RULE5]
            else
               r_next.txShift = REG_CLEAR; // [RULE3]
         end
         // last bit of a write: commit
         if (r_reg.bitCnt == 5'(FRAME_BITS - 1) && !frame[16])
         begin
            if (clockReg(frame[25:17]) || r_reg.state[3] || r_reg.state[4] ||
               r_reg.state[5]) // [RULE3] [RULE5]
            begin
               case (frame[25:17])
                  A_SENSOR_TYPE: r_next.sensorType = frame[15:0];
                  A_PLL_SOFT_RESET: r_next.pllSoftRst = frame[15:0];
                  A_CLK_GEN_SOFT_RESET: r_next.cgSoftRst = frame[15:0];
                  A_PLL_CONTROL: r_next.pllCtrl = frame[15:0];
                  A_PLL_CONFIG: r_next.pllCfg = frame[15:0];
                  A_CLOCK_INPUT: r_next.clkIn = frame[15:0];
                  A_LOCK_A: r_next.lockA = frame[15:0];
                  A_LOCK_B: r_next.lockB = frame[15:0];
                  A_CLOCK_MGMT: r_next.clkMgmt = frame[15:0];
                  A_LOGIC_ENABLE: r_next.logicEn = frame[15:0];
                  A_SEQ_ENABLE: r_next.seqEn = frame[15:0];
                  default: r_next.seqEn = r_reg.seqEn; // unmapped: ignored
               endcase
            end
         end
      end
      // answer bits leave on falling sclk, msb first
      if (fall && !r_reg.csS[1] && r_reg.bitCnt > 5'(ADDR_BITS))
      begin
         r_next.miso = r_reg.txShift[15];
         r_next.txShift = {r_reg.txShift[14:0], 1'b0};
      end
      // lock detector counts only while the pll is really running
      if (pllOn && r_reg.state != LP_STANDBY && r_reg.state != POWER_OFF)
      begin
         if (r_reg.lockCnt == 10'(LOCK_CYC - 1))
            r_next.locked = 1'b1; // [RULE16]
         else
            r_next.lockCnt = r_reg.lockCnt + 10'h001;
      end
      else
      begin
         r_next.lockCnt = 10'h000;
         r_next.locked = 1'b0;
      end
      // states follow the reset pin, the written settings and the pll lock flag [RULE1] [RULE2]
      if (!r_reg.rstS[1])
         r_next.state = POWER_OFF;
      else if (!clkRunning)
         r_next.state = LP_STANDBY; // [RULE3]
      else if (!logicRun)
         r_next.state = STANDBY1; // [RULE4]
      else if (!r_reg.logicEn[0])
         r_next.state = STANDBY2; // [RULE5]
      else if (!r_reg.seqEn[0])
         r_next.state = IDLE; // [RULE6]
      else
         r_next.state = RUNNING; // [RULE6]
      // reset pin held: registers back to defaults
      if (!r_reg.rstS[1])
      begin
         r_next.sensorType = REG_CLEAR;
         r_next.pllSoftRst = SOFT_RESET_ON;
         r_next.cgSoftRst = SOFT_RESET_ON;
         r_next.pllCtrl = REG_CLEAR;
         r_next.pllCfg = REG_CLEAR;
         r_next.clkIn = REG_CLEAR;
         r_next.lockA = REG_CLEAR;
         r_next.lockB = REG_CLEAR;
         r_next.clkMgmt = REG_CLEAR;
         r_next.logicEn = REG_CLEAR;
         r_next.seqEn = REG_CLEAR;
      end
      // taken from the next values so the flag moves with the register write
      r_next.logicClk = r_next.clkMgmt[1] && (r_next.state != POWER_OFF); // [RULE5]
   end

   // state register, frozen while ce is low
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r_reg <= '0;
         r_reg.sclkS <= 2'h0;
         r_reg.csS <= 2'h3;
         r_reg.pllSoftRst <= SOFT_RESET_ON;
         r_reg.cgSoftRst <= SOFT_RESET_ON;
         r_reg.state <= POWER_OFF;
      end
      else if (ce)
         r_reg <= r_next;
   end

   assign link.miso = r_reg.miso;
   assign powerState = r_reg.state;
   assign pllLocked = r_reg.locked;
   assign logicClkOn = r_reg.logicClk;
   assign sequencerOn = r_reg.seqEn[0];
endmodule

// file: rtl/sensor_host.sv
// controller end: apb registers, power up and clock management uploads
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module sensor_host
   import sensor_seq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   sensor_link_if.host link
);
   typedef enum logic [5:0] {
      H_IDLE = 6'h01,
      H_RESET = 6'h02,
      H_WAIT = 6'h04,
      H_FRAME = 6'h08,
      H_GAP = 6'h10,
      H_NEXT = 6'h20
   } host_state_e;
   typedef struct packed {
      logic [1:0] misoS; // synchroniser, [0] feeds [1] only
      logic [1:0] mode;
      logic usePll;
      logic colour;
      logic run;
      logic busy;
      logic done;
      logic lockSeen;
      logic [3:0] step;
      logic [8:0] cnt;
      logic [4:0] bitCnt;
      logic [25:0] txShift;
      logic [15:0] rxData;
      logic sclk;
      logic csN;
      logic mosi;
      logic resetN;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      host_state_e state;
   } host_s;
   host_s r_reg, r_next;
   logic pllOn; // pll used in a serial mode

   // frame for one upload step: address, read flag, data
   function automatic logic [25:0] stepFrame(input host_s s);
      logic [15:0] cm;
      logic par;
      logic s8;
      par = (s.mode == MODE_PAR10);
      s8 = (s.mode == MODE_SER8);
      // [RULE11] [RULE20]
      if (par)
         cm = CM_SER8_PLL;
      else if (s8)
         cm = s.usePll ? CM_SER8_PLL : CM_SER8_NOPLL;
      else
         cm = s.usePll ? CM_SER10_PLL : CM_SER10_NOPLL;
      case (s.step)
         4'd0: stepFrame = {A_SENSOR_TYPE, 1'b0,
            (par ? TYPE_PARALLEL : TYPE_MONO) | {15'h0000, s.colour}}; // [RULE10]
         4'd1: stepFrame = {A_CLOCK_MGMT, 1'b0, cm}; // [RULE11]
         4'd2: stepFrame = {A_CLOCK_INPUT, 1'b0,
            (!par && !s.usePll) ? ONE : REG_CLEAR}; // [RULE14]
         4'd3: stepFrame = {A_PLL_CONFIG, 1'b0, s8 ? PLLCFG_8 : PLLCFG_10}; // [RULE12]
         4'd4: stepFrame = {A_LOCK_A, 1'b0, s8 ? LOCKA_8 : LOCKA_10}; // [RULE12]
         4'd5: stepFrame = {A_LOCK_B, 1'b0, s8 ? LOCKB_8 : LOCKB_10}; // [RULE12]
         4'd6: stepFrame = {A_PLL_SOFT_RESET, 1'b0, REG_CLEAR}; // [RULE13]
         4'd7: stepFrame = {A_PLL_CONTROL, 1'b0,
            par ? PLL_BYPASS : PLL_ENABLE}; // [RULE13] [RULE15]
         4'd8: stepFrame = {A_PLL_STATUS, 1'b1, REG_CLEAR}; // [RULE17]
         4'd9: stepFrame = {A_CLK_GEN_SOFT_RESET, 1'b0, REG_CLEAR}; // [RULE19]
         4'd10: stepFrame = {A_CLOCK_MGMT, 1'b0, cm | CM_LOGIC_CLK}; // [RULE20]
         4'd11: stepFrame = {A_LOGIC_ENABLE, 1'b0, ONE}; // [RULE19]
         default: stepFrame = {A_SEQ_ENABLE, 1'b0, ONE};
      endcase
   endfunction

   // whether a step belongs to the chosen mode
   function automatic logic stepUsed(input host_s s, input logic pll);
      case (s.step)
         4'd3, 4'd4, 4'd5, 4'd6: stepUsed = pll;
         4'd7: stepUsed = pll || (s.mode == MODE_PAR10); // [RULE15]
         4'd8: stepUsed = pll; // [RULE17] [RULE18]
         4'd12: stepUsed = s.run;
         default: stepUsed = 1'b1;
      endcase
   endfunction

   // next state: apb slave plus upload sequencer
   always_comb
   begin
      r_next = r_reg;
      pllOn = r_reg.usePll && (r_reg.mode != MODE_PAR10);
      r_next.misoS = {r_reg.misoS[0], link.miso};
      // apb: one wait state, answer from flops
      r_next.pready = 1'b0;
      r_next.pslverr = 1'b0;
      if (psel && penable && !r_reg.pready)
      begin
         r_next.pready = 1'b1;
         r_next.prdata = 32'h00000000;
         if (paddr == A_CTRL)
         begin
            r_next.prdata = {26'h0000000, r_reg.run, r_reg.colour, r_reg.usePll,
               r_reg.mode, 1'b0};
            // settings locked while an upload runs
            if (pwrite && !r_reg.busy)
            begin
               r_next.mode = pwdata[2:1];
               r_next.usePll = pwdata[3];
               r_next.colour = pwdata[4];
               r_next.run = pwdata[5];
               if (pwdata[0])
               begin
                  r_next.busy = 1'b1;
                  r_next.done = 1'b0;
                  r_next.lockSeen = 1'b0;
                  r_next.cnt = 9'h000;
                  r_next.resetN = 1'b0;
                  r_next.state = H_RESET;
               end
            end
         end
         else if (paddr == A_STAT)
            r_next.prdata = {24'h000000, r_reg.step, 1'b0, r_reg.lockSeen,
               r_reg.done, r_reg.busy};
         else
            r_next.pslverr = 1'b1; // unmapped
      end
      case (r_reg.state)
         H_IDLE:
         begin
            r_next.csN = 1'b1;
         end
         H_RESET:
         begin
            // reset held low, released after the clock is stable [RULE7]
            r_next.cnt = r_reg.cnt + 9'h001;
            if (r_reg.cnt == 9'(RESET_HOLD_CYC - 1))
            begin
               r_next.resetN = 1'b1;
               r_next.cnt = 9'h000;
               r_next.state = H_WAIT;
            end
         end
         H_WAIT:
         begin
            // no upload before the power up wait has passed [RULE7]
            r_next.cnt = r_reg.cnt + 9'h001;
            if (r_reg.cnt == 9'(POWER_WAIT_CYC - 1))
            begin
               // step 0 is loaded here, so a stale step never leaks
               r_next.step = 4'h0;
               r_next.cnt = 9'h000;
               r_next.state = H_NEXT;
            end
         end
         H_FRAME:
         begin
            r_next.csN = 1'b0;
            r_next.mosi = r_reg.txShift[25];
            r_next.cnt = r_reg.cnt + 9'h001;
            if (r_reg.cnt == 9'(SCK_HALF - 1))
            begin
               r_next.sclk = 1'b1;
               r_next.rxData = {r_reg.rxData[14:0], r_reg.misoS[1]};
            end
            else if (r_reg.cnt == 9'(2 * SCK_HALF - 1))
            begin
               r_next.sclk = 1'b0;
               r_next.cnt = 9'h000;
               r_next.txShift = {r_reg.txShift[24:0], 1'b0};
               r_next.bitCnt = r_reg.bitCnt + 5'h01;
               if (r_reg.bitCnt == 5'(FRAME_BITS - 1))
                  r_next.state = H_GAP;
            end
         end
         H_GAP:
         begin
            // whole frame ends before the next starts [RULE21] [RULE9]
            r_next.csN = 1'b1;
            r_next.cnt = r_reg.cnt + 9'h001;
            if (r_reg.cnt == 9'(GAP_CYCLES - 1))
            begin
               r_next.cnt = 9'h000;
               if (r_reg.step == 4'(POLL_STEP) && !r_reg.rxData[0])
               begin
                  // not locked yet: poll again [RULE17]
                  r_next.bitCnt = 5'h00;
                  r_next.txShift = stepFrame(r_reg);
                  r_next.state = H_FRAME;
               end
               else
               begin
                  if (r_reg.step == 4'(POLL_STEP))
                     r_next.lockSeen = 1'b1;
                  r_next.step = r_reg.step + 4'h1;
                  r_next.state = H_NEXT;
               end
            end
         end
         H_NEXT:
         begin
            // skip steps that the mode does not use, one per cycle
            if (r_reg.step > 4'(LAST_STEP))
            begin
               r_next.busy = 1'b0;
               r_next.done = 1'b1;
               r_next.state = H_IDLE;
            end
            else if (!stepUsed(r_reg, pllOn))
               r_next.step = r_reg.step + 4'h1;
            else
            begin
               r_next.bitCnt = 5'h00;
               r_next.txShift = stepFrame(r_reg);
               r_next.state = H_FRAME;
            end
         end
         default:
            r_next.state = H_IDLE;
      endcase
   end

   // state register, frozen while ce is low
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r_reg <= '0;
         r_reg.csN <= 1'b1;
         r_reg.state <= H_IDLE;
      end
      else if (ce)
         r_reg <= r_next;
   end

   assign link.sclk = r_reg.sclk;
   assign link.csN = r_reg.csN;
   assign link.mosi = r_reg.mosi;
   assign link.resetN = r_reg.resetN; // [RULE8] reference clock is the bench's
   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
endmodule

// file: rtl/sensor_link_if.sv
// serial control link between controller and sensor
`timescale 1ns/1ns
interface sensor_link_if;
   logic sclk; // serial clock made by the controller
   logic csN; // frame select, active low
   logic mosi; // controller to sensor data
   logic miso; // sensor to controller data
   logic resetN; // sensor reset, active low
   modport host (output sclk, output csN, output mosi, input miso, output resetN);
   modport device (input sclk, input csN, input mosi, output miso, input resetN);
endinterface

// file: rtl/sensor_seq_pkg.sv
// constants shared by the sensor clock sequencer ends
// Behaviour
// RULE1 - six power states, moved only by controller
// RULE2 - each state move follows explicit controller action
// RULE3 - low power standby: clocks off, only clock registers
// RULE4 - standby 1: clock receiver runs, logic clock off
// RULE5 - standby 2: logic clock on, all registers open
// RULE6 - idle all blocks; sequencer enable means running
// RULE7 - clock, then reset release, then wait 10 us
// RULE8 - reference clock pin, or lvds clock when bypassed
// RULE9 - first clock writes in fixed order per mode
// RULE10 - sensor type written first, values zero to three
// RULE11 - clock management at 32, per mode value
// RULE12 - pll config then two lock detector registers
// RULE13 - release pll soft reset, then enable pll
// RULE14 - serial without pll: enable lvds clock input
// RULE15 - parallel mode: pll bypass value written
// RULE16 - device starts pll, lock flag readable
// RULE17 - poll lock flag before second phase if pll
// RULE18 - parallel variant never checks lock flag
// RULE19 - release clock gen reset, logic clock, logic blocks
// RULE20 - logic clock values per mode at 32
// RULE21 - each serial write completes before the next
package sensor_seq_pkg;
   // link frame: 9 address bits, read flag, 16 data bits
   localparam int FRAME_BITS = 26;
   localparam int ADDR_BITS = 9;
   localparam int CLK_NS = 40;
   // sclk half period in system clocks, slow enough for both synchronisers
   localparam int SCK_HALF = 8;
   localparam int GAP_CYCLES = 4;
   localparam int RESET_HOLD_NS = 1000;
   localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int POWER_WAIT_NS = 10000;
   localparam int POWER_WAIT_CYC = (POWER_WAIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int LOCK_TIME_NS = 20000;
   localparam int LOCK_CYC = (LOCK_TIME_NS + CLK_NS - 1) / CLK_NS;
   // device register addresses
   localparam logic [8:0] A_SENSOR_TYPE = 9'h002;
   localparam logic [8:0] A_PLL_SOFT_RESET = 9'h008;
   localparam logic [8:0] A_CLK_GEN_SOFT_RESET = 9'h009;
   localparam logic [8:0] A_PLL_CONTROL = 9'h010;
   localparam logic [8:0] A_PLL_CONFIG = 9'h011;
   localparam logic [8:0] A_CLOCK_INPUT = 9'h014;
   localparam logic [8:0] A_LOCK_A = 9'h01a;
   localparam logic [8:0] A_LOCK_B = 9'h01b;
   localparam logic [8:0] A_CLOCK_MGMT = 9'h020;
   localparam logic [8:0] A_LOGIC_ENABLE = 9'h022;
   localparam logic [8:0] A_PLL_STATUS = 9'h018;
   localparam logic [8:0] A_SEQ_ENABLE = 9'h0c0;
   // device register reset values
   localparam logic [15:0] SOFT_RESET_ON = 16'h0001;
   localparam logic [15:0] REG_CLEAR = 16'h0000;
   // values written by the controller
   localparam logic [15:0] TYPE_MONO = 16'h0000;
   localparam logic [15:0] TYPE_PARALLEL = 16'h0002;
   localparam logic [15:0] CM_SER8_PLL = 16'h200c;
   localparam logic [15:0] CM_SER8_NOPLL = 16'h2008;
   localparam logic [15:0] CM_SER10_PLL = 16'h2004;
   localparam logic [15:0] CM_SER10_NOPLL = 16'h2000;
   localparam logic [15:0] CM_LOGIC_CLK = 16'h0002;
   localparam logic [15:0] PLLCFG_8 = 16'h210f;
   localparam logic [15:0] PLLCFG_10 = 16'h2113;
   localparam logic [15:0] LOCKA_8 = 16'h1180;
   localparam logic [15:0] LOCKB_8 = 16'hccbc;
   localparam logic [15:0] LOCKA_10 = 16'h2280;
   localparam logic [15:0] LOCKB_10 = 16'h3d2d;
   localparam logic [15:0] PLL_ENABLE = 16'h0003;
   localparam logic [15:0] PLL_BYPASS = 16'h0007;
   localparam logic [15:0] ONE = 16'h0001;
   // output modes
   localparam logic [1:0] MODE_SER8 = 2'h0;
   localparam logic [1:0] MODE_SER10 = 2'h1;
   localparam logic [1:0] MODE_PAR10 = 2'h2;
   // controller apb map
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam int LAST_STEP = 12;
   localparam int POLL_STEP = 8;
   // sensor operating states, one-hot
   typedef enum logic [5:0] {
      POWER_OFF = 6'h01,
      LP_STANDBY = 6'h02,
      STANDBY1 = 6'h04,
      STANDBY2 = 6'h08,
      IDLE = 6'h10,
      RUNNING = 6'h20
   } sensor_state_e;
endpackage

// file: tb/sensor_seq_chk.sv
// link and sensor state checks between the two ends
`timescale 1ns/1ns
module sensor_seq_chk
   import sensor_seq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic csN,
   input wire logic mosi,
   input wire logic resetN,
   input wire logic [5:0] powerState,
   input wire logic pllLocked,
   input wire logic logicClkOn,
   input wire logic sequencerOn
);
   logic [4:0] bitCnt; // sclk rises in this frame
   logic [9:0] sinceRst; // cycles since reset release, saturating
   logic [9:0] inS1; // cycles in standby 1, saturating so no wrap
   // helper counters
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bitCnt <= 5'h00;
         sinceRst <= 10'h000;
         inS1 <= 10'h000;
      end
      else
      begin
         bitCnt <= csN ? 5'h00 : bitCnt + 5'($rose(sclk));
         sinceRst <= !resetN ? 10'h000 : sinceRst + 10'(sinceRst != 10'h3ff);
         inS1 <= (powerState != STANDBY1) ? 10'h000 : inS1 + 10'(inS1 != 10'h3ff);
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // sensor drops to power off soon after its reset pin falls
   sequence offSoon;
      ##[1:4] (powerState == POWER_OFF);
   endsequence
   AST_ONEHOT: assert property ($onehot(powerState)) else $error("state not one-hot");
   AST_OFF: assert property ($fell(resetN) |-> offSoon) else $error("no power off");
   AST_HOLD: assert property ($rose(resetN) |-> !$past(resetN, 24))
      else $error("reset pulse short");
   AST_WAIT: assert property ($fell(csN) |-> sinceRst >= 10'(POWER_WAIT_CYC))
      else $error("frame too soon after reset");
   AST_RUN: assert property (powerState == RUNNING |-> sequencerOn && logicClkOn)
      else $error("running without enables");
   AST_S2: assert property (powerState inside {STANDBY2, IDLE} |-> $past(logicClkOn))
      else $error("logic clock off");
   AST_LOCK: assert property ($rose(pllLocked) |->
      powerState == STANDBY1 && inS1 >= 10'(LOCK_CYC - 1)) else $error("lock too early");
   AST_FRAME: assert property ($rose(csN) |-> bitCnt == 5'(FRAME_BITS))
      else $error("frame length");
   AST_MOSI: assert property (!csN && sclk && $past(sclk) |-> $stable(mosi))
      else $error("data moved while clock high");
   AST_IDLE: assert property (csN |-> !sclk) else $error("clock runs outside frame");
endmodule

// file: tb/tb.sv
// bench joining controller end and sensor end over the link
`timescale 1ns/1ns
module tb;
   import sensor_seq_pkg::*;
   logic sys_clk = 1'b0; // 25 MHz
   logic nrst = 1'b0; // async, active low
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   logic [5:0] powerState;
   logic pllLocked, logicClkOn, sequencerOn;
   logic [25:0] sh; // frame being snooped
   logic [24:0] got[$]; // write frames seen: address, data
   int nRd, compares, miscompares;
   sensor_link_if linkIf();
   sensor_host sensor_host_inst (.sys_clk(sys_clk), .nrst(nrst), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(linkIf));
   sensor_device sensor_device_inst (.sys_clk(sys_clk), .nrst(nrst), .ce(1'b1), .link(linkIf),
      .powerState(powerState), .pllLocked(pllLocked), .logicClkOn(logicClkOn),
      .sequencerOn(sequencerOn));
   sensor_seq_chk sensor_seq_chk_inst (.sys_clk(sys_clk), .nrst(nrst), .sclk(linkIf.sclk),
      .csN(linkIf.csN), .mosi(linkIf.mosi), .resetN(linkIf.resetN), .powerState(powerState),
      .pllLocked(pllLocked), .logicClkOn(logicClkOn), .sequencerOn(sequencerOn));
   initial forever #(CLK_NS / 2) sys_clk = ~sys_clk; // shared reference clock
   // snoop the wire, msb first
   always @(posedge linkIf.sclk)
      if (!linkIf.csN)
         sh = {sh[24:0], linkIf.mosi};
   // a frame closes when select rises; reads only counted
   always @(posedge linkIf.csN)
      if (sh[16])
         nRd++;
      else
         got.push_back({sh[25:17], sh[15:0]});
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // one apb transfer; the first edge keeps a gap after a release
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
         @(posedge sys_clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // start an upload, wait for it, judge wire frames and end state
   task upload(input logic [5:0] c, input logic [24:0] e[$], input logic [5:0] st,
      input logic lk);
      int i;
      got.delete();
      nRd = 0;
      apb(1'b1, A_CTRL, {26'h0, c});
      apb(1'b0, A_STAT, 32'h0);
      chk("busy", 32'h1, {31'h0, rd[0]});
      i = 0;
      while (rd[1:0] !== 2'b10 && i < 20000)
      begin
         apb(1'b0, A_STAT, 32'h0);
         i++;
      end
      chk("lockSeen", {31'h0, lk}, {31'h0, rd[2]});
      chk("step", 32'(LAST_STEP + 1), {28'h0, rd[7:4]});
      chk("frames", e.size(), got.size());
      foreach (e[k]) chk("frame", {7'h0, e[k]}, {7'h0, got[k]});
      chk("state", {26'h0, st}, {26'h0, powerState});
      chk("lock", {31'h0, lk}, {31'h0, pllLocked});
      chk("reads", {31'h0, lk}, {31'h0, nRd != 0});
      chk("seq", {31'h0, st == RUNNING}, {31'h0, sequencerOn});
      chk("logicClk", 32'h1, {31'h0, logicClkOn});
      apb(1'b0, A_CTRL, 32'h0);
      chk("ctrl", {26'h0, c & 6'h3e}, rd);
      $display("test %h done", c);
   endtask
   task unmapped;
      apb(1'b0, 8'h08, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      chk("rdata", 32'h0, rd);
      $display("test unmapped done");
   endtask
   task ser8Pll;
      upload(6'h39, '{{9'd2, 16'h0001}, {9'd32, 16'h200c}, {9'd20, 16'h0},
         {9'd17, 16'h210f}, {9'd26, 16'h1180}, {9'd27, 16'hccbc},
         {9'd8, 16'h0}, {9'd16, 16'h0003}, {9'd9, 16'h0},
         {9'd32, 16'h200e}, {9'd34, 16'h1}, {9'd192, 16'h1}}, RUNNING, 1'b1);
   endtask
   task ser10NoPll;
      upload(6'h03, '{{9'd2, 16'h0}, {9'd32, 16'h2000}, {9'd20, 16'h0001}, {9'd9, 16'h0},
         {9'd32, 16'h2002}, {9'd34, 16'h1}}, IDLE, 1'b0);
   endtask
   task par10;
      upload(6'h35, '{{9'd2, 16'h0003}, {9'd32, 16'h200c}, {9'd20, 16'h0}, {9'd16, 16'h0007},
         {9'd9, 16'h0}, {9'd32, 16'h200e}, {9'd34, 16'h1}, {9'd192, 16'h1}}, RUNNING,
         1'b0);
   endtask
   task finish_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // a hang counts as a mismatch
   initial
   begin
      #(CLK_NS * 60000);
      miscompares++;
      finish_test;
   end
   initial
   begin
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      unmapped;
      ser8Pll;
      ser10NoPll;
      par10;
      finish_test;
   end
endmodule
